// File: rtl/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= next_count != (AW + 1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule : byte_fifo

// File: rtl/serial_port.sv
// Serial port with control/status register, bit-tick shifters and transmit FIFO
`timescale 1ns/1ps
`include "serial_port_consts.svh"
module serial_port (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  input wire logic irq_enable,
  output logic serial_req,
  input wire logic baud_tick,
  input wire logic rxd,
  output logic txd,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  import serial_port_pkg::*;

  logic operating_mode_select;
  logic multiproc_enable;
  logic receive_enable_bit;
  logic ninth_transmit_bit;
  logic ninth_receive_bit;
  logic transmit_done_flag;
  logic receive_done_flag;
  logic ti_set;
  logic ri_set;
  logic accept;
  tx_state_e tx_st;
  rx_state_e rx_st;
  logic [2:0] tx_idx;
  logic [2:0] rx_idx;
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;
  logic rx_bit9;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;

  // Transmit bytes queue here so the source can run ahead of the line
  byte_fifo #(
    .WIDTH(`SPC_DATA_W),
    .DEPTH(`SPC_FIFO_DEPTH)
  ) tx_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  assign fifo_pop = (tx_st == TX_IDLE) && baud_tick && fifo_valid;

  // Plain control bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      operating_mode_select <= 1'b0;
      multiproc_enable <= 1'b0;
      receive_enable_bit <= 1'b0;
      ninth_transmit_bit <= 1'b0;
    end else if (ctrl_wr) begin
      operating_mode_select <= ctrl_wdata[`SPC_MODE_BIT];
      multiproc_enable <= ctrl_wdata[`SPC_MCE_BIT];
      receive_enable_bit <= ctrl_wdata[`SPC_REN_BIT];
      ninth_transmit_bit <= ctrl_wdata[`SPC_TB8_BIT];
    end
  end

  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      transmit_done_flag <= 1'b0;
      receive_done_flag <= 1'b0;
    end else begin
      transmit_done_flag <= ti_set ||
        (ctrl_wr ? ctrl_wdata[`SPC_TI_BIT] : transmit_done_flag);
      receive_done_flag <= ri_set ||
        (ctrl_wr ? ctrl_wdata[`SPC_RI_BIT] : receive_done_flag);
    end
  end

  // Hardware capture wins over a software write of the same bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ninth_receive_bit <= 1'b0;
    end else if (ri_set) begin
      ninth_receive_bit <= operating_mode_select ? rx_bit9 : rxd;
    end else if (ctrl_wr) begin
      ninth_receive_bit <= ctrl_wdata[`SPC_RB8_BIT];
    end
  end

  // Read data lags the register by one cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_rdata <= `SPC_RESET;
      serial_req <= 1'b0;
    end else begin
      ctrl_rdata <= {operating_mode_select, 1'b1, multiproc_enable, receive_enable_bit,
                     ninth_transmit_bit, ninth_receive_bit,
                     transmit_done_flag, receive_done_flag};
      serial_req <= irq_enable && (transmit_done_flag || receive_done_flag);
    end
  end

  // Transmitter: one bit per baud tick, txd shows the current bit
  assign ti_set = baud_tick && ((tx_st == TX_DATA && tx_idx == `SPC_LAST_BIT &&
                  !operating_mode_select) || tx_st == TX_NINTH);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st <= TX_IDLE;
      tx_idx <= 3'h0;
      tx_shift <= 8'h00;
      txd <= 1'b1;
    end else if (baud_tick) begin
      case (tx_st)
        TX_IDLE: begin
          if (fifo_valid) begin
            tx_shift <= fifo_data;
            txd <= 1'b0;
            tx_st <= TX_START;
          end
        end
        TX_START: begin
          txd <= tx_shift[0];
          tx_idx <= 3'h0;
          tx_st <= TX_DATA;
        end
        TX_DATA: begin
          if (tx_idx == `SPC_LAST_BIT) begin
            if (operating_mode_select) begin
              txd <= ninth_transmit_bit;
              tx_st <= TX_NINTH;
            end else begin
              txd <= 1'b1;
              tx_st <= TX_STOP;
            end
          end else begin
            tx_idx <= tx_idx + 3'h1;
            txd <= tx_shift[tx_idx + 3'h1];
          end
        end
        TX_NINTH: begin
          txd <= 1'b1;
          tx_st <= TX_STOP;
        end
        TX_STOP: begin
          tx_st <= TX_IDLE;
        end
        default: begin
          tx_st <= TX_IDLE;
          txd <= 1'b1;
        end
      endcase
    end
  end

  // Receiver: rxd sampled once per baud tick, start seen as a low sample
  always_comb begin
    if (operating_mode_select) begin
      accept = !multiproc_enable || rx_bit9;
    end else begin
      accept = !multiproc_enable || rxd;
    end
  end

  assign ri_set = baud_tick && rx_st == RX_STOP && receive_enable_bit && accept;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st <= RX_IDLE;
      rx_idx <= 3'h0;
      rx_shift <= 8'h00;
      rx_bit9 <= 1'b0;
    end else if (baud_tick) begin
      case (rx_st)
        RX_IDLE: begin
          if (receive_enable_bit && !rxd) begin
            rx_idx <= 3'h0;
            rx_st <= RX_DATA;
          end
        end
        RX_DATA: begin
          rx_shift <= {rxd, rx_shift[7:1]};
          rx_idx <= rx_idx + 3'h1;
          if (rx_idx == `SPC_LAST_BIT) begin
            rx_st <= operating_mode_select ? RX_NINTH : RX_STOP;
          end
        end
        RX_NINTH: begin
          rx_bit9 <= rxd;
          rx_st <= RX_STOP;
        end
        RX_STOP: begin
          rx_st <= RX_IDLE;
        end
        default: begin
          rx_st <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= ri_set;
      if (ri_set) begin
        rx_data <= rx_shift;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence stop_tick;
    rx_st == RX_STOP && baud_tick && receive_enable_bit && !ctrl_wr && !receive_done_flag;
  endsequence

  sequence stop_tick_8;
    stop_tick ##0 !operating_mode_select;
  endsequence

  sequence stop_tick_9;
    stop_tick ##0 operating_mode_select;
  endsequence

  sequence tx_last_data;
    tx_st == TX_DATA && tx_idx == `SPC_LAST_BIT && baud_tick;
  endsequence

  sequence tx_ninth_tick;
    tx_st == TX_NINTH && baud_tick;
  endsequence

  stop_check_a: assert property (stop_tick_8 ##0 (multiproc_enable && !rxd) |=>
    !receive_done_flag) else $error("receive flag set on bad stop bit");
  stop_ignore_a: assert property (stop_tick_8 ##0 !multiproc_enable |=>
    receive_done_flag && rx_valid) else $error("frame lost with stop check off");
  // A request two cycles on may only come from the transmit flag
  addr_filter_a: assert property (stop_tick_9 ##0 (multiproc_enable && !rx_bit9) |=>
    !receive_done_flag ##1 (!serial_req || $past(transmit_done_flag)))
    else $error("data frame not filtered");
  accept_all_a: assert property (stop_tick_9 ##0 !multiproc_enable |=>
    receive_done_flag) else $error("nine-bit frame not accepted");
  tx_eight_a: assert property (tx_last_data ##0 !operating_mode_select |=>
    transmit_done_flag && tx_st == TX_STOP && txd)
    else $error("transmit flag late in eight-bit mode");
  tx_nine_a: assert property (tx_ninth_tick |=>
    transmit_done_flag && txd && tx_st == TX_STOP) else $error("transmit flag not at stop");
  ti_hold_a: assert property (transmit_done_flag && !ctrl_wr |=> transmit_done_flag)
    else $error("transmit flag cleared by hardware");
  req_raise_a: assert property ((receive_done_flag || transmit_done_flag) && irq_enable
    |=> serial_req) else $error("service request missing");
  ri_moment_a: assert property (receive_done_flag && !$past(receive_done_flag) &&
    !$past(ctrl_wr) |-> $past(rx_st) == RX_STOP) else $error("receive flag off stop sampling");
  ren_off_a: assert property (rx_st == RX_IDLE && !receive_enable_bit |=>
    rx_st == RX_IDLE) else $error("reception while disabled");
  rb8_cap_a: assert property (ri_set && operating_mode_select |=>
    ninth_receive_bit == $past(rx_bit9)) else $error("ninth receive bit not captured");

  // Flags stay up until software acts; captures follow the frame format
  ninth_out_a: assert property (tx_last_data ##0 operating_mode_select |=>
    tx_st == TX_NINTH && txd == $past(ninth_transmit_bit))
    else $error("ninth transmit bit not sent");
  stop_cap_a: assert property (ri_set && !operating_mode_select |=>
    ninth_receive_bit == $past(rxd)) else $error("stop bit not captured");
  ri_hold_a: assert property (receive_done_flag && !ctrl_wr |=> receive_done_flag)
    else $error("receive flag cleared by hardware");
  ren_block_a: assert property (!receive_enable_bit && !ctrl_wr &&
    !receive_done_flag |=> !receive_done_flag) else $error("receive flag set while disabled");
  rx_flag_a: assert property (rx_valid |-> receive_done_flag)
    else $error("byte delivered without receive flag");
  // Request is registered, so it drops one cycle after both flags are clear
  req_drop_a: assert property (!transmit_done_flag &&
    !receive_done_flag |=> !serial_req) else $error("service request without a flag");
endmodule : serial_port

// File: rtl/serial_port_consts.svh
// Bit positions, reset value and sizes of the serial port control register
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
`define SPC_MODE_BIT 7
`define SPC_ONE_BIT 6
`define SPC_MCE_BIT 5
`define SPC_REN_BIT 4
`define SPC_TB8_BIT 3
`define SPC_RB8_BIT 2
`define SPC_TI_BIT 1
`define SPC_RI_BIT 0
`define SPC_RESET 8'h40
`define SPC_DATA_W 8
`define SPC_FIFO_DEPTH 8
`define SPC_LAST_BIT 3'h7
`endif

// File: rtl/serial_port_pkg.sv
// Types shared by the serial port design
package serial_port_pkg;
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b0_0001,
    TX_START = 5'b0_0010,
    TX_DATA  = 5'b0_0100,
    TX_NINTH = 5'b0_1000,
    TX_STOP  = 5'b1_0000
  } tx_state_e;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_DATA  = 4'b0010,
    RX_NINTH = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_e;
endpackage : serial_port_pkg

// File: testbench/remote_node.sv
// Remote serial node: drives frames on rxd, collects frames from txd
`timescale 1ns/1ps
module remote_node (
  input wire logic clk,
  input wire logic baud_tick,
  input wire logic txd,
  input wire logic nine,
  output logic rxd
);
  logic [8:0] got_q[$];
  logic [8:0] sh;
  int cnt = -1;
  initial rxd = 1'b1;
  // One sample per bit time, as the device does
  always @(posedge clk) begin
    if (baud_tick) begin
      if (cnt < 0) begin
        if (txd === 1'b0) cnt = 0;
      end else if (cnt < (nine ? 9 : 8)) begin
        sh[cnt] = txd;
        cnt++;
      end else begin
        if (!nine) sh[8] = txd;
        got_q.push_back(sh);
        cnt = -1;
      end
    end
  end
  task automatic send(input logic [8:0] bits, input int n, input logic stop);
    for (int i = 0; i < n + 2; i++) begin
      @(posedge clk iff baud_tick);
      @(negedge clk);
      rxd = (i == 0) ? 1'b0 : ((i <= n) ? bits[i-1] : stop);
    end
    @(posedge clk iff baud_tick);
    @(negedge clk);
    rxd = 1'b1;
  endtask : send
endmodule : remote_node

// File: testbench/tb.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
module tb;
  logic clk = 0, arst_n = 0, ctrl_wr = 0, irq_enable = 0, baud_tick = 0;
  logic tx_valid = 0, nine = 0, tick_on = 1;
  logic [7:0] ctrl_wdata = 8'h00, tx_data = 8'h00, ctrl_rdata, rx_data, r;
  logic serial_req, rxd, txd, tx_ready, rx_valid;
  int err_count = 0, checks = 0, cycles = 0, pulses = 0, div = 0;
  always #50 clk = ~clk;
  always @(negedge clk) begin
    div <= (div + 1) % 4;
    baud_tick <= tick_on && div == 3;
  end
  always @(posedge clk) begin
    cycles++;
    if (rx_valid === 1'b1) pulses++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  serial_port u_serial_port (.clk(clk), .arst_n(arst_n), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .irq_enable(irq_enable),
    .serial_req(serial_req), .baud_tick(baud_tick), .rxd(rxd), .txd(txd),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid));
  remote_node u_remote_node (.clk(clk), .baud_tick(baud_tick), .txd(txd),
    .nine(nine), .rxd(rxd));
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: bit %b want %b", $time, g, e);
    end
  endtask : chk1
  task automatic wr(input logic [7:0] v);
    @(negedge clk);
    ctrl_wr = 1'b1;
    ctrl_wdata = v;
    @(negedge clk);
    ctrl_wr = 1'b0;
  endtask : wr
  task automatic rd();
    repeat (2) @(negedge clk);
    r = ctrl_rdata;
  endtask : rd
  // Writing zeros to the flag bits doubles as the software clear
  task automatic cfg(input logic mode, mce, ren, tb8);
    wr({mode, 1'b1, mce, ren, tb8, 3'b000});
    nine = mode;
  endtask : cfg
  task automatic rx_case(input logic mode, mce, ren, ninth, stop, input logic [7:0] d);
    logic ok;
    int p0;
    cfg(mode, mce, ren, 1'b0);
    p0 = pulses;
    u_remote_node.send({ninth, d}, mode ? 9 : 8, stop);
    ok = ren && (!mce || (mode ? ninth : stop));
    rd();
    chk1(r[0], ok);
    chk1(pulses - p0 == int'(ok), 1'b1);
    if (ok) begin
      chk1(r[2], mode ? ninth : stop);
      chk8(rx_data, d);
    end
  endtask : rx_case
  // Ready read off the edge; it holds until the edge that takes the byte
  task automatic push(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
  endtask : push
  task automatic tx_case(input logic mode, tb8, input logic [7:0] d);
    logic [8:0] g;
    cfg(mode, 1'b0, 1'b0, tb8);
    irq_enable = 1'b1;
    push(d);
    tx_valid = 1'b0;
    for (int k = 0; k < 400 && ctrl_rdata[1] !== 1'b1; k++) @(negedge clk);
    chk1(ctrl_rdata[1], 1'b1);
    chk1(txd, 1'b1);
    for (int k = 0; k < 400 && u_remote_node.got_q.size() == 0; k++) @(negedge clk);
    g = u_remote_node.got_q.pop_front();
    chk8(g[7:0], d);
    chk1(g[8], mode ? tb8 : 1'b1);
    rd();
    chk1(r[1], 1'b1);
    chk1(serial_req, 1'b1);
    cfg(mode, 1'b0, 1'b0, tb8);
    repeat (3) @(negedge clk);
    chk1(serial_req, 1'b0);
    irq_enable = 1'b0;
  endtask : tx_case
  task automatic irq_case();
    irq_enable = 1'b1;
    rx_case(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h3c);
    repeat (30) @(negedge clk);
    chk1(serial_req, 1'b1);
    rd();
    chk1(r[0], 1'b1);
    cfg(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (3) @(negedge clk);
    chk1(serial_req, 1'b0);
    rx_case(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h96);
    repeat (3) @(negedge clk);
    chk1(serial_req, 1'b0);
    irq_enable = 1'b0;
  endtask : irq_case
  // Bit ticks held off so the far side cannot drain while filling
  task automatic fifo_case();
    logic [8:0] g;
    cfg(1'b0, 1'b0, 1'b0, 1'b0);
    tick_on = 1'b0;
    for (int i = 0; i < 8; i++) push(8'h10 + 8'(i));
    tx_valid = 1'b0;
    repeat (2) @(negedge clk);
    chk1(tx_ready, 1'b0);
    tick_on = 1'b1;
    for (int k = 0; k < 3000 && u_remote_node.got_q.size() < 8; k++) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      g = u_remote_node.got_q.pop_front();
      chk8(g[7:0], 8'h10 + 8'(i));
    end
    rd();
    chk1(r[1], 1'b1);
  endtask : fifo_case
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    @(negedge clk);
    chk8(ctrl_rdata, 8'h40);
    chk1(txd, 1'b1);
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    wr(8'h00);
    rd();
    chk8(r, 8'h40);
    for (int i = 0; i < 8; i++) begin
      rx_case(i[2], i[1], 1'b1, i[0], i[2] | i[0], 8'ha5 ^ 8'(i));
    end
    rx_case(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h5a);
    irq_case();
    tx_case(1'b0, 1'b0, 8'h35);
    tx_case(1'b1, 1'b0, 8'h4b);
    tx_case(1'b1, 1'b1, 8'h6c);
    fifo_case();
    report_and_stop();
  end
endmodule : tb
